//--- shared/sfc_pkg.sv
// constants, opcodes and states for the serial flash host
// assumes a 250 MHz mclk_i and one flash on the link
`default_nettype none
package sfc_pkg;
  // timing
  localparam int SFC_MCLK_NS  = 4;
  localparam int SFC_HALF_NS  = 16;
  localparam int SFC_CSH_NS   = 40;
  localparam int SFC_HALF_CYC = (SFC_HALF_NS + SFC_MCLK_NS - 1) / SFC_MCLK_NS;
  localparam int SFC_CSH_CYC  = (SFC_CSH_NS + SFC_MCLK_NS - 1) / SFC_MCLK_NS;
  localparam logic [3:0] SFC_DIV_LAST = 4'(2 * SFC_HALF_CYC - 1);
  localparam logic [3:0] SFC_DIV_SAMP = 4'(SFC_HALF_CYC + 2);
  localparam logic [3:0] SFC_DIV_HI   = 4'(SFC_HALF_CYC);
  localparam logic [3:0] SFC_DIV_HOLD = 4'(SFC_HALF_CYC - 2);
  localparam logic [3:0] SFC_CSH_LAST = 4'(SFC_CSH_CYC - 1);
  localparam logic [3:0] SFC_CPB1     = 4'h8;
  localparam logic [3:0] SFC_CPB2     = 4'h4;
  localparam logic [3:0] SFC_CPB4     = 4'h2;
  // register map
  localparam logic [7:0] SFC_OFF_CMD  = 8'h00;
  localparam logic [7:0] SFC_OFF_ADR  = 8'h04;
  localparam logic [7:0] SFC_OFF_CTL  = 8'h08;
  localparam logic [7:0] SFC_OFF_TX   = 8'h0C;
  localparam logic [7:0] SFC_OFF_RX   = 8'h10;
  localparam logic [7:0] SFC_OFF_ST   = 8'h14;
  localparam int SFC_CMD_LEN_LSB = 16;
  localparam int SFC_CTL_HOLD    = 0;
  localparam int SFC_CTL_QOK     = 1;
  localparam int SFC_ST_BUSY     = 0;
  localparam int SFC_ST_TXF      = 1;
  localparam int SFC_ST_RXF      = 2;
  localparam int SFC_ST_REF      = 3;
  localparam int SFC_ST_HELD     = 4;
  localparam logic [15:0] SFC_LEN_SR  = 16'h0001;
  localparam logic [15:0] SFC_LEN_WSR = 16'h0002;
  localparam logic [15:0] SFC_LEN_0   = 16'h0000;
  localparam logic [7:0]  SFC_BYTE_RST = 8'h00;
  // opcodes
  localparam logic [7:0] OP_READ = 8'h03, OP_FRD = 8'h0B, OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIO = 8'hBB, OP_QOR = 8'h6B, OP_QIO = 8'hEB;
  localparam logic [7:0] OP_PGE = 8'h81, OP_SCE = 8'h20, OP_HBE = 8'h52;
  localparam logic [7:0] OP_BKE = 8'hD8, OP_CE0 = 8'h60, OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_PGM = 8'h02, OP_DPP = 8'hA2, OP_QPG = 8'h32;
  localparam logic [7:0] OP_WEN = 8'h06, OP_WDI = 8'h04, OP_VWE = 8'h50;
  localparam logic [7:0] OP_SAE = 8'h44, OP_SAP = 8'h42, OP_SAR = 8'h48;
  localparam logic [7:0] OP_SRL = 8'h05, OP_SRH = 8'h35, OP_WSR = 8'h01;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA  = 3'b100,
    ST_STALL = 3'b101,
    ST_DONE  = 3'b110
  } sfc_state_t;
endpackage
`default_nettype wire

//--- logic/sfc_host.sv
// host controller for a multi-line serial nor flash
// assumes the flash on dl_* pins, software on the reg_* port
//
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none
module sfc_host (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic      [3:0]  dl_o,
  output logic      [3:0]  dl_oe_o,
  input  wire logic [3:0]  dl_i
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  sfc_pkg::sfc_state_t st_q;
  sfc_pkg::sfc_state_t st_d;
  logic [7:0]  op_q;
  logic [23:0] adr_q;
  logic [15:0] len_q;
  logic [15:0] len_d;
  logic [7:0]  sr_q;
  logic [7:0]  sr_d;
  logic [3:0]  clk_q;
  logic [3:0]  clk_d;
  logic [1:0]  bl_q;
  logic [1:0]  bl_d;
  logic [3:0]  div_q;
  logic [3:0]  div_d;
  logic        hreq_q;
  logic        qok_q;
  logic        hold_q;
  logic        hold_d;
  logic [7:0]  tx_q;
  logic        txf_q;
  logic [7:0]  rx_q;
  logic        rxf_q;
  logic        ref_q;
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic        rx_set;
  logic        tx_take;
  logic        ref_set;
  logic        start;
  logic [31:0] st_word;

  // ----------------------------------------
  // register port decode
  // ----------------------------------------
  wire        idle   = st_q == sfc_pkg::ST_IDLE;
  wire        wr_cmd = reg_wr_i && reg_addr_i == sfc_pkg::SFC_OFF_CMD;
  wire        wr_adr = reg_wr_i && reg_addr_i == sfc_pkg::SFC_OFF_ADR;
  wire        wr_ctl = reg_wr_i && reg_addr_i == sfc_pkg::SFC_OFF_CTL;
  wire        wr_tx  = reg_wr_i && reg_addr_i == sfc_pkg::SFC_OFF_TX;
  wire        wr_st  = reg_wr_i && reg_addr_i == sfc_pkg::SFC_OFF_ST;
  wire        rd_rx  = reg_rd_i && reg_addr_i == sfc_pkg::SFC_OFF_RX;
  wire [7:0]  w_op   = reg_wdata_i[7:0];
  wire [15:0] w_len  = reg_wdata_i[sfc_pkg::SFC_CMD_LEN_LSB +: 16];
  wire n_quad  = w_op inside {sfc_pkg::OP_QOR, sfc_pkg::OP_QIO,
                              sfc_pkg::OP_QPG};
  wire n_sr    = w_op inside {sfc_pkg::OP_SRL, sfc_pkg::OP_SRH};
  wire n_wsr   = w_op == sfc_pkg::OP_WSR;
  // no data phase for erases and latch commands
  wire n_nodat = w_op inside {sfc_pkg::OP_PGE, sfc_pkg::OP_SCE,
                              sfc_pkg::OP_HBE, sfc_pkg::OP_BKE,
                              sfc_pkg::OP_CE0, sfc_pkg::OP_CE1,
                              sfc_pkg::OP_WEN, sfc_pkg::OP_WDI,
                              sfc_pkg::OP_VWE, sfc_pkg::OP_SAE};
  wire [15:0] n_len = n_sr ? sfc_pkg::SFC_LEN_SR :
                      n_wsr ? sfc_pkg::SFC_LEN_WSR :
                      n_nodat ? sfc_pkg::SFC_LEN_0 : w_len;

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  wire op_adr3 = op_q inside {sfc_pkg::OP_READ, sfc_pkg::OP_FRD,
                              sfc_pkg::OP_DOR, sfc_pkg::OP_DIO,
                              sfc_pkg::OP_QOR, sfc_pkg::OP_QIO,
                              sfc_pkg::OP_PGE, sfc_pkg::OP_SCE,
                              sfc_pkg::OP_HBE, sfc_pkg::OP_BKE,
                              sfc_pkg::OP_PGM, sfc_pkg::OP_DPP,
                              sfc_pkg::OP_QPG, sfc_pkg::OP_SAE,
                              sfc_pkg::OP_SAP, sfc_pkg::OP_SAR};
  wire op_dmy  = op_q inside {sfc_pkg::OP_FRD, sfc_pkg::OP_DOR,
                              sfc_pkg::OP_DIO, sfc_pkg::OP_QOR,
                              sfc_pkg::OP_QIO, sfc_pkg::OP_SAR};
  wire op_rd   = op_q inside {sfc_pkg::OP_READ, sfc_pkg::OP_FRD,
                              sfc_pkg::OP_DOR, sfc_pkg::OP_DIO,
                              sfc_pkg::OP_QOR, sfc_pkg::OP_QIO,
                              sfc_pkg::OP_SAR, sfc_pkg::OP_SRL,
                              sfc_pkg::OP_SRH};
  wire dw2 = op_q inside {sfc_pkg::OP_DOR, sfc_pkg::OP_DIO,
                          sfc_pkg::OP_DPP};
  wire dw4 = op_q inside {sfc_pkg::OP_QOR, sfc_pkg::OP_QIO,
                          sfc_pkg::OP_QPG};
  wire aw2 = op_q == sfc_pkg::OP_DIO;
  wire aw4 = op_q == sfc_pkg::OP_QIO;
  wire op_quad = dw4;

  // ----------------------------------------
  // phase width and serial clock divider
  // ----------------------------------------
  wire in_ad  = st_q inside {sfc_pkg::ST_ADDR, sfc_pkg::ST_DUMMY};
  wire in_dt  = st_q inside {sfc_pkg::ST_DATA, sfc_pkg::ST_STALL};
  wire ph_w2  = (in_ad && aw2) || (in_dt && dw2);
  wire ph_w4  = (in_ad && aw4) || (in_dt && dw4);
  wire run    = st_q inside {sfc_pkg::ST_CMD, sfc_pkg::ST_ADDR,
                             sfc_pkg::ST_DUMMY, sfc_pkg::ST_DATA};
  wire active = run || st_q == sfc_pkg::ST_STALL;
  wire t_samp = run && !hold_q && div_q == sfc_pkg::SFC_DIV_SAMP;
  wire t_fall = run && !hold_q && div_q == sfc_pkg::SFC_DIV_LAST;
  wire last   = clk_q == 4'h1;
  wire [3:0] cpb_a = aw4 ? sfc_pkg::SFC_CPB4 :
                     aw2 ? sfc_pkg::SFC_CPB2 : sfc_pkg::SFC_CPB1;
  wire [3:0] cpb_d = dw4 ? sfc_pkg::SFC_CPB4 :
                     dw2 ? sfc_pkg::SFC_CPB2 : sfc_pkg::SFC_CPB1;
  // msb first, wide lanes carry the top bits of each group
  wire [7:0] sr_out = ph_w4 ? {sr_q[3:0], 4'h0} :
                      ph_w2 ? {sr_q[5:0], 2'h0} : {sr_q[6:0], 1'b0};
  wire [7:0] sr_in  = ph_w4 ? {sr_q[3:0], s2_q} :
                      ph_w2 ? {sr_q[5:0], s2_q[1:0]} :
                      {sr_q[6:0], s2_q[1]};
  // reads need room in rx, writes need a byte in tx
  wire go   = !hold_q && (op_rd ? !rxf_q : txf_q);
  wire sclk_d = run && div_d >= sfc_pkg::SFC_DIV_HI;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    st_d    = st_q;
    sr_d    = sr_q;
    clk_d   = clk_q;
    bl_d    = bl_q;
    div_d   = div_q;
    len_d   = len_q;
    rx_set  = 1'b0;
    tx_take = 1'b0;
    ref_set = 1'b0;
    start   = 1'b0;
    unique case (st_q)
      sfc_pkg::ST_IDLE:
      begin
        if (wr_cmd && n_quad && !qok_q)
          ref_set = 1'b1;
        else if (wr_cmd)
        begin
          start = 1'b1;
          st_d  = sfc_pkg::ST_CMD;
          sr_d  = w_op;
          clk_d = sfc_pkg::SFC_CPB1;
          div_d = 4'h0;
          len_d = n_len;
        end
      end
      sfc_pkg::ST_CMD, sfc_pkg::ST_ADDR,
      sfc_pkg::ST_DUMMY, sfc_pkg::ST_DATA:
      begin
        if (!hold_q)
          div_d = t_fall ? 4'h0 : div_q + 4'h1;
        if (t_samp && st_q == sfc_pkg::ST_DATA && op_rd)
          sr_d = sr_in;
        if (t_fall && !(st_q == sfc_pkg::ST_DATA && op_rd))
          sr_d = sr_out;
        if (t_fall)
          clk_d = clk_q - 4'h1;
        // byte boundary: only here may the frame end
        if (t_fall && last)
        begin
          if (st_q == sfc_pkg::ST_CMD && op_adr3)
          begin
            st_d  = sfc_pkg::ST_ADDR;
            bl_d  = 2'h2;
            sr_d  = adr_q[23:16];
            clk_d = cpb_a;
          end
          else if (st_q == sfc_pkg::ST_ADDR && bl_q != 2'h0)
          begin
            bl_d  = bl_q - 2'h1;
            sr_d  = bl_q == 2'h2 ? adr_q[15:8] : adr_q[7:0];
            clk_d = cpb_a;
          end
          else if (st_q == sfc_pkg::ST_ADDR && op_dmy)
          begin
            st_d  = sfc_pkg::ST_DUMMY;
            sr_d  = sfc_pkg::SFC_BYTE_RST;
            clk_d = cpb_a;
          end
          else if (st_q == sfc_pkg::ST_DATA)
          begin
            rx_set = op_rd;
            len_d  = len_q - 16'h1;
            st_d   = len_q == 16'h1 ? sfc_pkg::ST_DONE
                                    : sfc_pkg::ST_STALL;
          end
          else
            st_d = len_q == 16'h0 ? sfc_pkg::ST_DONE
                                  : sfc_pkg::ST_STALL;
        end
      end
      sfc_pkg::ST_STALL:
      begin
        // clock parked low while software catches up
        if (go)
        begin
          st_d    = sfc_pkg::ST_DATA;
          div_d   = 4'h0;
          clk_d   = cpb_d;
          tx_take = !op_rd;
          if (!op_rd)
            sr_d = tx_q;
        end
      end
      sfc_pkg::ST_DONE:
      begin
        div_d = div_q + 4'h1;
        if (div_q == sfc_pkg::SFC_CSH_LAST)
        begin
          st_d  = sfc_pkg::ST_IDLE;
          div_d = 4'h0;
        end
      end
      default:
        st_d = sfc_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // hold
  // ----------------------------------------
  // enters and leaves only with the clock low and not about to rise
  assign hold_d = hold_q ? hreq_q
                : hreq_q && active && !op_quad && !sclk_o
                  && div_q <= sfc_pkg::SFC_DIV_HOLD;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  wire drive = st_q inside {sfc_pkg::ST_CMD, sfc_pkg::ST_ADDR}
             || (st_q == sfc_pkg::ST_DUMMY && !ph_w2 && !ph_w4)
             || (st_q == sfc_pkg::ST_DATA && !op_rd);
  wire [3:0] bits = ph_w4 ? sr_q[7:4] :
                    ph_w2 ? {2'h0, sr_q[7:6]} : {3'h0, sr_q[7]};
  wire [3:0] lanes = ph_w4 ? 4'hF : ph_w2 ? 4'h3 : 4'h1;
  wire [3:0] oe_d;
  wire [3:0] val_d;
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_lane
      // protect and hold pins stay driven unless quad uses them
      wire side = (i >= 2) && !ph_w4;
      assign oe_d[i]  = side || (drive && lanes[i]);
      // pin tracks the next hold state, so it settles before sclk rises
      assign val_d[i] = side ? (i == 3 ? !hold_d : 1'b1) : bits[i];
    end
  endgenerate

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb
  begin
    st_word = 32'h0;
    st_word[sfc_pkg::SFC_ST_BUSY] = !idle;
    st_word[sfc_pkg::SFC_ST_TXF]  = txf_q;
    st_word[sfc_pkg::SFC_ST_RXF]  = rxf_q;
    st_word[sfc_pkg::SFC_ST_REF]  = ref_q;
    st_word[sfc_pkg::SFC_ST_HELD] = hold_q;
  end
  wire [31:0] ctl_word = {30'h0, qok_q, hreq_q};
  wire [31:0] rd_d =
    !reg_rd_i ? 32'h0 :
    reg_addr_i == sfc_pkg::SFC_OFF_CMD ? {len_q, 8'h0, op_q} :
    reg_addr_i == sfc_pkg::SFC_OFF_ADR ? {8'h0, adr_q} :
    reg_addr_i == sfc_pkg::SFC_OFF_CTL ? ctl_word :
    reg_addr_i == sfc_pkg::SFC_OFF_TX  ? {24'h0, tx_q} :
    reg_addr_i == sfc_pkg::SFC_OFF_RX  ? {24'h0, rx_q} :
    reg_addr_i == sfc_pkg::SFC_OFF_ST  ? st_word : 32'h0;

  // ----------------------------------------
  // flip-flops
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q  <= sfc_pkg::ST_IDLE;
      sr_q  <= sfc_pkg::SFC_BYTE_RST;
      clk_q <= 4'h0;
      bl_q  <= 2'h0;
      div_q <= 4'h0;
      len_q <= sfc_pkg::SFC_LEN_0;
      op_q  <= sfc_pkg::SFC_BYTE_RST;
    end
    else
    begin
      st_q  <= st_d;
      sr_q  <= sr_d;
      clk_q <= clk_d;
      bl_q  <= bl_d;
      div_q <= div_d;
      len_q <= len_d;
      if (start)
        op_q <= w_op;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      adr_q  <= 24'h0;
      hreq_q <= 1'b0;
      qok_q  <= 1'b0;
      tx_q   <= sfc_pkg::SFC_BYTE_RST;
      txf_q  <= 1'b0;
      rx_q   <= sfc_pkg::SFC_BYTE_RST;
      rxf_q  <= 1'b0;
      ref_q  <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      if (wr_adr && idle)
        adr_q <= reg_wdata_i[23:0];
      if (wr_ctl)
      begin
        hreq_q <= reg_wdata_i[sfc_pkg::SFC_CTL_HOLD];
        qok_q  <= reg_wdata_i[sfc_pkg::SFC_CTL_QOK];
      end
      if (wr_tx)
        tx_q <= reg_wdata_i[7:0];
      if (rx_set)
        rx_q <= sr_q;
      // a set in the same cycle as the clear wins
      txf_q  <= wr_tx || (txf_q && !tx_take);
      rxf_q  <= rx_set || (rxf_q && !rd_rx);
      ref_q  <= ref_set
             || (ref_q && !(wr_st && reg_wdata_i[sfc_pkg::SFC_ST_REF]));
      hold_q <= hold_d;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q        <= 4'h0;
      s2_q        <= 4'h0;
      sclk_o      <= 1'b0;
      cs_n_o      <= 1'b1;
      dl_o        <= 4'hC;
      dl_oe_o     <= 4'hC;
      reg_rdata_o <= 32'h0;
    end
    else
    begin
      s1_q        <= dl_i;
      s2_q        <= s1_q;
      sclk_o      <= sclk_d;
      cs_n_o      <= st_d inside {sfc_pkg::ST_IDLE, sfc_pkg::ST_DONE};
      dl_o        <= val_d;
      dl_oe_o     <= oe_d;
      reg_rdata_o <= rd_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  property p_cmd_first;
    $fell(cs_n_o) |-> st_q == sfc_pkg::ST_CMD
                      && clk_q == sfc_pkg::SFC_CPB1 && sr_q == op_q;
  endproperty
  a_cmd_first: assert property (p_cmd_first)
    else $error("frame did not open with the opcode");

  property p_mode0;
    cs_n_o |-> !sclk_o;
  endproperty
  a_mode0: assert property (p_mode0)
    else $error("serial clock high while deselected");

  property p_byte_bound;
    $rose(cs_n_o) |-> $past(t_fall) && $past(clk_q) == 4'h1;
  endproperty
  a_byte_bound: assert property (p_byte_bound)
    else $error("chip select rose off a byte boundary");

  property p_quad_refuse;
    idle && wr_cmd && n_quad && !qok_q |=> ref_q && cs_n_o && idle;
  endproperty
  a_quad_refuse: assert property (p_quad_refuse)
    else $error("quad command sent without quad_enable_bit");

  property p_hold_clk;
    $changed(hold_q) |-> !sclk_o && !$past(sclk_o) && dl_o[3] != hold_q;
  endproperty
  a_hold_clk: assert property (p_hold_clk)
    else $error("hold changed near a high serial clock");

  property p_hold_quad;
    hold_q |-> !op_quad;
  endproperty
  a_hold_quad: assert property (p_hold_quad)
    else $error("hold during a quad command");

  property p_hold_cs;
    hold_q |=> !cs_n_o;
  endproperty
  a_hold_cs: assert property (p_hold_cs)
    else $error("chip select rose during hold");

  property p_rd_release;
    st_q == sfc_pkg::ST_DATA && op_rd |=> dl_oe_o[1:0] == 2'h0;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("host drove a data line during read data");

  property p_addr_seq;
    st_q == sfc_pkg::ST_CMD ##1 st_q == sfc_pkg::ST_ADDR
      |-> bl_q == 2'h2 && op_adr3;
  endproperty
  a_addr_seq: assert property (p_addr_seq)
    else $error("address phase not three bytes");

  property p_sr_len;
    start && n_sr |=> len_q == sfc_pkg::SFC_LEN_SR;
  endproperty
  a_sr_len: assert property (p_sr_len)
    else $error("status read length not one byte");

  c_quad_data: cover property (st_q == sfc_pkg::ST_DATA && dw4);
  c_hold: cover property ($rose(hold_q));
  c_refuse: cover property ($rose(ref_q));
  c_write: cover property (tx_take);
endmodule
`default_nettype wire

//--- sim/sfc_flash_model.sv
// behavioural serial nor flash on the far side of the host
// assumes the bench resolves the shared data lines for both ends
`default_nettype none
module sfc_flash_model (
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] dl_i,
  output logic      [3:0] dl_o,
  output logic      [3:0] dl_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int          nb;
  int          k;
  logic [7:0]  op;
  logic [7:0]  b;
  logic [23:0] adr;
  logic        ign;
  logic        write_latch;
  logic        busy;
  logic        live;
  // quad data takes over the hold pin, so hold is not looked at there
  assign live = dl_i[3] || (op == 8'h6B && nb >= 40);
  // ---------------------------------------------------------------
  // shift in on clock rise; hold low freezes the link
  // ---------------------------------------------------------------
  always @(posedge sclk_i)
    if (!cs_n_i && !ign && live)
    begin
      nb = nb + 1;
      if (nb <= 32)
        adr = {adr[22:0], dl_i[0]};
      if (nb == 8)
      begin
        op  = adr[7:0];
        ign = !(op inside {8'h03, 8'h0B, 8'h3B, 8'h05, 8'h35, 8'h06,
                           8'h04, 8'h20, 8'h6B});
      end
    end
  // ---------------------------------------------------------------
  // shift out on clock fall
  // ---------------------------------------------------------------
  always @(negedge sclk_i)
    if (!cs_n_i && !ign && live)
    begin
      k = nb - ((op == 8'h05 || op == 8'h35) ? 8 : (op == 8'h03) ? 32 : 40);
      b = (op == 8'h05) ? {6'h00, write_latch, busy} :
          (op == 8'h35) ? 8'h00 :
          8'(adr[7:0] + k / ((op == 8'h3B) ? 4 : (op == 8'h6B) ? 2 : 8))
          ^ 8'h5A;
      if (op == 8'h6B && k >= 0)
      begin
        dl_oe_o = 4'hF;
        dl_o    = b[7 - 4 * (k % 2) -: 4];
      end
      else if (op == 8'h3B && k >= 0)
      begin
        dl_oe_o   = 4'h3;
        dl_o[1:0] = b[7 - 2 * (k % 4) -: 2];
      end
      else if (k >= 0 && op inside {8'h03, 8'h0B, 8'h05, 8'h35})
      begin
        dl_oe_o = 4'h2;
        dl_o[1] = b[7 - k % 8];
      end
    end
  // ---------------------------------------------------------------
  // chip select framing
  // ---------------------------------------------------------------
  always @(negedge cs_n_i)
  begin
    nb  = 0;
    ign = 1'b0;
  end
  // write-type work only on a byte boundary and never while busy
  always @(posedge cs_n_i)
  begin
    // nonblocking: the last clock fall may land in the same time step
    dl_oe_o <= 4'h0;
    if (nb != 0 && nb % 8 == 0 && !ign && !busy)
    begin
      if (op == 8'h06)
        write_latch = 1'b1;
      if (op == 8'h04)
        write_latch = 1'b0;
      // the latch stays set until the erase completes
      if (op == 8'h20 && nb == 32 && write_latch)
      begin
        busy = 1'b1;
        busy <= #2000 1'b0;
        write_latch <= #2000 1'b0;
      end
    end
  end
  initial
  begin
    nb      = 0;
    op      = 8'h00;
    adr     = 24'h0;
    ign     = 1'b0;
    write_latch = 1'b0;
    busy    = 1'b0;
    dl_o    = 4'h0;
    dl_oe_o = 4'h0;
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the serial flash host
// assumes sfc_host and sfc_flash_model; reads checked via a queue
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, rst_i, reg_wr_i, reg_rd_i, sclk_o, cs_n_o;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic [31:0] reg_rdata_o;
  logic [3:0]  dl_o, dl_oe_o, dl_i, fm_o, fm_oe;
  logic        ck, pend;
  logic [31:0] v;
  logic [7:0]  st;
  logic [23:0] a;
  logic [63:0] nt;
  logic [63:0] qe [$];
  int          n_fail, n_tests;
  // released lines show the inverse of the host's last level
  assign dl_i = (dl_oe_o & dl_o) | (~dl_oe_o & fm_oe & fm_o)
              | (~dl_oe_o & ~fm_oe & ~dl_o);
  sfc_host u_sfc_host (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sclk_o, .cs_n_o, .dl_o,
    .dl_oe_o, .dl_i);
  sfc_flash_model u_sfc_flash_model (.sclk_i(sclk_o), .cs_n_i(cs_n_o),
    .dl_i(dl_i), .dl_o(fm_o), .dl_oe_o(fm_oe));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask
  // c high queues a note of mask and expected value
  task automatic rd(input logic [7:0] ad, input logic c,
                    input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    ck         <= c;
    if (c)
      qe.push_back({m, e});
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic poll(input int b, input logic val);
    for (int i = 0; i < 3000; i++)
    begin
      rd(sfc_pkg::SFC_OFF_ST, 1'b0, 32'h0, 32'h0);
      if (v[b] === val)
        return;
    end
    n_fail++;
    print_verdict();
  endtask
  task automatic run(input logic [7:0] op, input int n);
    wr(sfc_pkg::SFC_OFF_ADR, {8'h00, a});
    wr(sfc_pkg::SFC_OFF_CMD, {16'(n), 8'h00, op});
    for (int i = 0; i < n; i++)
    begin
      poll(sfc_pkg::SFC_ST_RXF, 1'b1);
      rd(sfc_pkg::SFC_OFF_RX, 1'b1, 32'hFF, {24'h0,
        (op == sfc_pkg::OP_SRL) ? st : (op == sfc_pkg::OP_SRH) ? 8'h00 :
        (a[7:0] + 8'(i)) ^ 8'h5A});
    end
    poll(sfc_pkg::SFC_ST_BUSY, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // monitor: oldest note against the answer cycle
  // ---------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    if (pend)
    begin
      nt = qe.pop_front();
      check(reg_rdata_o & nt[63:32], nt[31:0]);
    end
    pend <= reg_rd_i && ck;
  end
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, ck, pend} = 4'h0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h0;
    {n_fail, n_tests} = 64'h0;
    st = 8'h00;
    void'($urandom(6));
    a = 24'($urandom());
    repeat (20) @(posedge mclk_i);
    check({cs_n_o, sclk_o, dl_oe_o}, 32'h2C);
    rst_i <= 1'b0;
    rd(sfc_pkg::SFC_OFF_ST, 1'b1, 32'h1F, 32'h0);
    rd(8'h18, 1'b1, 32'hFFFF_FFFF, 32'h0);
    run(sfc_pkg::OP_SRL, 1);
    run(8'hFF, 0);
    run(sfc_pkg::OP_WEN, 0);
    st = 8'h02;
    run(sfc_pkg::OP_SRL, 1);
    run(sfc_pkg::OP_SRH, 1);
    run(sfc_pkg::OP_SCE, 0);
    st = 8'h03;
    run(sfc_pkg::OP_SRL, 1);
    repeat (600) @(posedge mclk_i);
    st = 8'h00;
    run(sfc_pkg::OP_SRL, 1);
    run(sfc_pkg::OP_WEN, 0);
    run(sfc_pkg::OP_WDI, 0);
    run(sfc_pkg::OP_SCE, 0);
    run(sfc_pkg::OP_SRL, 1);
    foreach (qe[i]) ;
    for (int j = 0; j < 3; j++)
    begin
      a = 24'($urandom());
      run((j == 0) ? sfc_pkg::OP_READ : (j == 1) ? sfc_pkg::OP_FRD :
          sfc_pkg::OP_DOR, 3);
    end
    wr(sfc_pkg::SFC_OFF_ADR, {8'h00, a});
    wr(sfc_pkg::SFC_OFF_CMD, {16'h1, 8'h00, sfc_pkg::OP_READ});
    wr(sfc_pkg::SFC_OFF_CTL, 32'h1);
    repeat (12) @(posedge mclk_i);
    rd(sfc_pkg::SFC_OFF_ST, 1'b1, 32'h10, 32'h10);
    wr(sfc_pkg::SFC_OFF_CTL, 32'h0);
    poll(sfc_pkg::SFC_ST_RXF, 1'b1);
    rd(sfc_pkg::SFC_OFF_RX, 1'b1, 32'hFF, {24'h0, a[7:0] ^ 8'h5A});
    poll(sfc_pkg::SFC_ST_BUSY, 1'b0);
    wr(sfc_pkg::SFC_OFF_CMD, {24'h0, sfc_pkg::OP_QOR});
    rd(sfc_pkg::SFC_OFF_ST, 1'b1, 32'h9, 32'h8);
    wr(sfc_pkg::SFC_OFF_ST, 32'h8);
    rd(sfc_pkg::SFC_OFF_ST, 1'b1, 32'h8, 32'h0);
    wr(sfc_pkg::SFC_OFF_CTL, 32'h2);
    a = 24'($urandom());
    run(sfc_pkg::OP_QOR, 2);
    wr(sfc_pkg::SFC_OFF_TX, {24'h0, a[15:8]});
    wr(sfc_pkg::SFC_OFF_CMD, {16'h1, 8'h00, sfc_pkg::OP_PGM});
    poll(sfc_pkg::SFC_ST_BUSY, 1'b0);
    rd(sfc_pkg::SFC_OFF_ST, 1'b1, 32'h6, 32'h0);
    repeat (3) @(posedge mclk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
